// ==== hw/mts_tx_stats.sv ====
// Transmit error statistics: four saturating, clear-on-read counters.
// Assumes event pulses and the read port come from logic on ref_clk;
// each read request is a one-cycle pulse.
`timescale 1ns/1ps
module mts_tx_stats (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic cut_through_en,
   input wire logic plca_en,
   input wire logic underflow_abort,
   input wire logic tx_ok,
   input wire logic [4:0] tx_col_count,
   input wire logic plca_logical_col,
   input wire logic excess_col_abort,
   input wire logic rd_en,
   input wire logic [3:0] rd_mms,
   input wire logic [7:0] rd_addr,
   output logic rd_valid,
   output logic [31:0] rd_data
);
   localparam int SW = mts_pkg::MTS_SHORT_W;
   localparam int LW = mts_pkg::MTS_LONG_W;

   mts_cnt_if #(.W(SW)) uf_if ();
   mts_cnt_if #(.W(LW)) sc_if ();
   mts_cnt_if #(.W(LW)) mc_if ();
   mts_cnt_if #(.W(SW)) xc_if ();

   logic logic_col_q;
   logic logic_col_d;
   logic rd_valid_q;
   logic [31:0] rd_data_q;
   logic [31:0] rd_data_d;

   // Address decode for the four counters
   wire space_hit = rd_en && (rd_mms == mts_pkg::MTS_MMS);
   wire sel_uf = space_hit && (rd_addr == mts_pkg::MTS_OFS_UNDERFLOW);
   wire sel_sc = space_hit && (rd_addr == mts_pkg::MTS_OFS_SINGLE_COL);
   wire sel_mc = space_hit && (rd_addr == mts_pkg::MTS_OFS_MULTI_COL);
   wire sel_xc = space_hit && (rd_addr == mts_pkg::MTS_OFS_EXCESS_COL);

   // Logical collision seen during this frame's arbitration; cleared
   // when the frame is sent or abandoned, but a new one in that cycle is kept
   assign logic_col_d = plca_logical_col ? 1'b1 :
                        (tx_ok || excess_col_abort) ? 1'b0 : logic_col_q;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         logic_col_q <= 1'b0;
      end else begin
         logic_col_q <= logic_col_d;
      end
   end

   // Event classification
   wire logic_seen = logic_col_q || plca_logical_col;
   wire phys_single = (tx_col_count == mts_pkg::MTS_ONE_COL);
   wire phys_multi = (tx_col_count > mts_pkg::MTS_ONE_COL);
   // Store-and-forward cannot underflow; a stray pulse there is ignored
   assign uf_if.inc = underflow_abort && cut_through_en;
   assign sc_if.inc = tx_ok && (plca_en ? logic_seen : phys_single);
   // No gating by plca_en: real faults must stay visible
   assign mc_if.inc = tx_ok && phys_multi;
   assign xc_if.inc = excess_col_abort;

   // Clearing reads
   assign uf_if.clr = sel_uf;
   assign sc_if.clr = sel_sc;
   assign mc_if.clr = sel_mc;
   assign xc_if.clr = sel_xc;

   mts_sat_counter #(.W(SW)) u_uf (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .port(uf_if.ctr)
   );
   mts_sat_counter #(.W(LW)) u_sc (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .port(sc_if.ctr)
   );
   mts_sat_counter #(.W(LW)) u_mc (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .port(mc_if.ctr)
   );
   mts_sat_counter #(.W(SW)) u_xc (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .port(xc_if.ctr)
   );

   // Read mux, zero above each field and for unmapped offsets
   assign rd_data_d = sel_uf ? {{(32-SW){1'b0}}, uf_if.cnt} :
                      sel_sc ? {{(32-LW){1'b0}}, sc_if.cnt} :
                      sel_mc ? {{(32-LW){1'b0}}, mc_if.cnt} :
                      sel_xc ? {{(32-SW){1'b0}}, xc_if.cnt} :
                      32'h0000_0000;

   // Read answer one cycle after the request; value before clearing
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rd_valid_q <= 1'b0;
         rd_data_q <= 32'h0000_0000;
      end else begin
         rd_valid_q <= rd_en;
         rd_data_q <= rd_data_d;
      end
   end

   assign rd_valid = rd_valid_q;
   assign rd_data = rd_data_q;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   property p_uf_sf_quiet;
      !cut_through_en && !sel_uf |=> uf_if.cnt == $past(uf_if.cnt);
   endproperty
   a_uf_sf_quiet: assert property (p_uf_sf_quiet)
      else $error("underflow counter moved in store-and-forward");

   property p_uf_count;
      underflow_abort && cut_through_en && !sel_uf
         && uf_if.cnt != mts_pkg::MTS_SHORT_MAX[SW-1:0]
         |=> uf_if.cnt == $past(uf_if.cnt) + 10'h001;
   endproperty
   a_uf_count: assert property (p_uf_count)
      else $error("underflow abort not counted");

   property p_sc_phys;
      !plca_en && tx_ok && tx_col_count == 5'h01 && !sel_sc
         && sc_if.cnt != mts_pkg::MTS_LONG_MAX[LW-1:0]
         |=> sc_if.cnt == $past(sc_if.cnt) + 18'h00001;
   endproperty
   a_sc_phys: assert property (p_sc_phys)
      else $error("single collision frame not counted");

   property p_sc_logic;
      plca_en && tx_ok && logic_col_q && !sel_sc
         && sc_if.cnt != mts_pkg::MTS_LONG_MAX[LW-1:0]
         |=> sc_if.cnt == $past(sc_if.cnt) + 18'h00001;
   endproperty
   a_sc_logic: assert property (p_sc_logic)
      else $error("logical collision frame not counted");

   property p_sc_plca_phys;
      plca_en && tx_ok && !logic_seen && !sel_sc
         |=> sc_if.cnt == $past(sc_if.cnt);
   endproperty
   a_sc_plca_phys: assert property (p_sc_plca_phys)
      else $error("physical collision counted with avoidance on");

   property p_mc_count;
      tx_ok && tx_col_count > 5'h01 && !sel_mc
         && mc_if.cnt != mts_pkg::MTS_LONG_MAX[LW-1:0]
         |=> mc_if.cnt == $past(mc_if.cnt) + 18'h00001;
   endproperty
   a_mc_count: assert property (p_mc_count)
      else $error("multiple collision frame not counted");

   property p_xc_count;
      excess_col_abort && !sel_xc
         && xc_if.cnt != mts_pkg::MTS_SHORT_MAX[SW-1:0]
         |=> xc_if.cnt == $past(xc_if.cnt) + 10'h001;
   endproperty
   a_xc_count: assert property (p_xc_count)
      else $error("excessive collision abort not counted");

   property p_rd_value;
      sel_sc |=> rd_valid && rd_data == {14'h0000, $past(sc_if.cnt)};
   endproperty
   a_rd_value: assert property (p_rd_value)
      else $error("read returned wrong count");

   property p_rd_clear;
      sel_mc && !mc_if.inc |=> mc_if.cnt == 18'h00000;
   endproperty
   a_rd_clear: assert property (p_rd_clear)
      else $error("read did not clear multi collision count");

   property p_upper_zero;
      rd_valid |-> rd_data[31:18] == 14'h0000;
   endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("bits above field not zero");

   property p_short_upper;
      sel_uf || sel_xc |=> rd_data[31:10] == 22'h000000;
   endproperty
   a_short_upper: assert property (p_short_upper)
      else $error("bits above short field not zero");

   property p_sat;
      !sel_xc |=> xc_if.cnt >= $past(xc_if.cnt);
   endproperty
   a_sat: assert property (p_sat)
      else $error("excessive collision counter wrapped");

   // Answer follows every request by exactly one cycle, never otherwise
   property p_rd_answer;
      rd_en |=> rd_valid;
   endproperty
   a_rd_answer: assert property (p_rd_answer)
      else $error("read request got no answer");

   property p_rd_single;
      !rd_en |=> !rd_valid;
   endproperty
   a_rd_single: assert property (p_rd_single)
      else $error("answer without a read request");

   // Unmapped offsets and other maps read as zero
   property p_unmapped;
      rd_en && !(sel_uf || sel_sc || sel_mc || sel_xc)
         |=> rd_data == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read returned nonzero data");

   // Flag must drop when a frame is sent or abandoned so the next frame starts clean
   property p_flag_clear;
      (tx_ok || excess_col_abort) && !plca_logical_col |=> !logic_col_q;
   endproperty
   a_flag_clear: assert property (p_flag_clear)
      else $error("logical collision flag survived frame end");

   c_uf_read: cover property (sel_uf ##1 rd_valid);
   c_logic_frame: cover property (plca_en && plca_logical_col ##[1:20] tx_ok);
   c_multi: cover property (tx_ok && tx_col_count > 5'h01);
   c_read_inc: cover property (sel_sc && sc_if.inc);
endmodule // mts_tx_stats

// ==== common/mts_pkg.sv ====
// Constants for the transmit error statistics counter block.
// Assumes a single 100 MHz clock and a same-clock register read port.
// Behaviour
// - Each frame aborted on transmit buffer underflow adds one to a 10-bit counter.
// - Underflow aborts count only in cut-through mode, never in store-and-forward.
// - Each frame sent after exactly one collision adds one to an 18-bit counter.
// - With collision avoidance on, the single-collision count follows logical collisions.
// - Each frame sent after more than one collision adds one to an 18-bit counter.
// - Each frame abandoned past the retry limit adds one to a 10-bit counter.
// - Multiple and excessive collision counts are never suppressed by collision avoidance.
// - Every counter stops at its all-ones maximum instead of wrapping.
// - Reading a counter returns its value and clears it to zero, or to one when an event lands in the read cycle.
package mts_pkg;
   // Register space and offsets
   localparam logic [3:0] MTS_MMS = 4'h1;
   localparam logic [7:0] MTS_OFS_UNDERFLOW = 8'h3b;
   localparam logic [7:0] MTS_OFS_SINGLE_COL = 8'h3c;
   localparam logic [7:0] MTS_OFS_MULTI_COL = 8'h3d;
   localparam logic [7:0] MTS_OFS_EXCESS_COL = 8'h3e;
   // Field widths, all fields start at bit 0
   localparam int MTS_SHORT_W = 10;
   localparam int MTS_LONG_W = 18;
   localparam int MTS_DATA_W = 32;
   localparam int MTS_COL_W = 5;
   // Reset value of every counter
   localparam logic [31:0] MTS_CNT_RESET = 32'h0000_0000;
   // Saturation values
   localparam logic [31:0] MTS_SHORT_MAX = 32'h0000_03ff;
   localparam logic [31:0] MTS_LONG_MAX = 32'h0003_ffff;
   // Physical collision count meaning a single collision
   localparam logic [4:0] MTS_ONE_COL = 5'h01;
endpackage

// ==== common/mts_cnt_if.sv ====
// Interface between the statistics top and one saturating counter.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface mts_cnt_if #(parameter int W = 10);
   logic inc;
   logic clr;
   logic [W-1:0] cnt;
   modport ctr (input inc, input clr, output cnt);
   modport ctl (output inc, output clr, input cnt);
endinterface // mts_cnt_if

// ==== hw/mts_sat_counter.sv ====
// One saturating, clear-on-read statistics counter.
// Assumes inc and clr are single-cycle pulses on ref_clk.
`timescale 1ns/1ps
module mts_sat_counter #(
   parameter int W = 10
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   mts_cnt_if.ctr port
);
   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   wire at_max = &cnt_q;
   wire [W-1:0] one = {{(W-1){1'b0}}, 1'b1};

   // Clear wins over hold, but an increment in the clear cycle survives
   assign cnt_d = port.clr ? (port.inc ? one : '0) :
                  (port.inc && !at_max) ? cnt_q + one : cnt_q;

   // Counter register
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cnt_q <= mts_pkg::MTS_CNT_RESET[W-1:0];
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign port.cnt = cnt_q;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   property p_sat_hold;
      (&cnt_q) && port.inc && !port.clr |=> (&cnt_q);
   endproperty
   a_sat_hold: assert property (p_sat_hold)
      else $error("counter wrapped past maximum");

   property p_clr_inc;
      port.clr && port.inc |=> cnt_q == one;
   endproperty
   a_clr_inc: assert property (p_clr_inc)
      else $error("increment lost during clearing read");

   property p_clr_zero;
      port.clr && !port.inc |=> cnt_q == '0;
   endproperty
   a_clr_zero: assert property (p_clr_zero)
      else $error("read did not clear counter");

   property p_step;
      !port.clr && port.inc && !(&cnt_q) |=> cnt_q == $past(cnt_q) + one;
   endproperty
   a_step: assert property (p_step)
      else $error("counter did not advance by one");

   c_saturate: cover property ((&cnt_q) && port.inc);
endmodule // mts_sat_counter

// ==== dv/mts_host_model.sv ====
// Host model: reads statistics registers over the same-clock read port.
// Assumes callers enter its task just after a falling edge of ref_clk.
`timescale 1ns/1ps
module mts_host_model (
   input wire logic ref_clk,
   output logic rd_en,
   output logic [3:0] rd_mms,
   output logic [7:0] rd_addr,
   input wire logic rd_valid,
   input wire logic [31:0] rd_data
);
   // Quiet bus at time zero
   initial begin
      rd_en = 1'b0;
      rd_mms = 4'h0;
      rd_addr = 8'h00;
   end
   // Request stands for one rising edge, answer taken while it stands;
   // one idle edge after, so back-to-back reads never rewrite rd_en at once
   task automatic rd(input logic [3:0] mms, input logic [7:0] addr,
         output logic v, output logic [31:0] d);
      rd_en = 1'b1;
      rd_mms = mms;
      rd_addr = addr;
      @(negedge ref_clk);
      v = rd_valid;
      d = rd_data;
      rd_en = 1'b0;
      // Idle select lines show garbage, never a stale copy
      rd_mms = ~mms;
      rd_addr = ~addr;
      @(negedge ref_clk);
   endtask
endmodule // mts_host_model

// ==== dv/mts_tx_stats_tb.sv ====
// Testbench for the transmit statistics counters.
// Assumes the host model and the design files are compiled first.
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fail_count++; \
   $display("BAD t=%0t got %h exp %h", $time, a, e); end end
module mts_tx_stats_tb;
   logic ref_clk, rst_n, cut_through_en, plca_en, underflow_abort;
   logic tx_ok, plca_logical_col, excess_col_abort, rd_en, rd_valid;
   logic [4:0] tx_col_count;
   logic [3:0] rd_mms;
   logic [7:0] rd_addr;
   logic [31:0] rd_data;
   int fail_count = 0;
   int n_tests = 0;
   localparam logic [7:0] A_UF = mts_pkg::MTS_OFS_UNDERFLOW;
   localparam logic [7:0] A_SC = mts_pkg::MTS_OFS_SINGLE_COL;
   localparam logic [7:0] A_MC = mts_pkg::MTS_OFS_MULTI_COL;
   localparam logic [7:0] A_XC = mts_pkg::MTS_OFS_EXCESS_COL;

   mts_tx_stats dut (.ref_clk(ref_clk), .rst_n(rst_n),
      .cut_through_en(cut_through_en), .plca_en(plca_en),
      .underflow_abort(underflow_abort), .tx_ok(tx_ok),
      .tx_col_count(tx_col_count), .plca_logical_col(plca_logical_col),
      .excess_col_abort(excess_col_abort), .rd_en(rd_en),
      .rd_mms(rd_mms), .rd_addr(rd_addr), .rd_valid(rd_valid),
      .rd_data(rd_data));
   mts_host_model host (.ref_clk(ref_clk), .rd_en(rd_en), .rd_mms(rd_mms),
      .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data));

   // Clock, 10 ns period
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // Event pulses held for n cycles, then one quiet cycle
   task automatic ev(input int u, t, l, x, input logic [4:0] c,
         input int n);
      underflow_abort = u[0];
      tx_ok = t[0];
      plca_logical_col = l[0];
      excess_col_abort = x[0];
      tx_col_count = c;
      repeat (n) @(negedge ref_clk);
      underflow_abort = 1'b0;
      tx_ok = 1'b0;
      plca_logical_col = 1'b0;
      excess_col_abort = 1'b0;
      tx_col_count = ~c;
      @(negedge ref_clk);
   endtask
   // Read one register, expect an answer and a value
   task automatic rdc(input logic [3:0] m, input logic [7:0] a,
         input logic [31:0] e);
      logic v;
      logic [31:0] d;
      host.rd(m, a, v, d);
      `CHK(v, 1'b1)
      `CHK(d, e)
   endtask
   task automatic t_reset();
      for (int i = 0; i < 4; i++) begin
         rdc(4'h1, A_UF + 8'(i), mts_pkg::MTS_CNT_RESET);
      end
      ev(1, 0, 0, 0, 5'h00, 1);
      rdc(4'h1, 8'h3f, 32'h0000_0000);
      rdc(4'h0, A_UF, 32'h0000_0000);
      rdc(4'h1, A_UF, 32'h0000_0001);
      $display("test reset done");
   endtask
   task automatic t_underflow();
      cut_through_en = 1'b0;
      ev(1, 0, 0, 0, 5'h00, 3);
      rdc(4'h1, A_UF, 32'h0000_0000);
      cut_through_en = 1'b1;
      ev(1, 0, 0, 0, 5'h00, 3);
      rdc(4'h1, A_UF, 32'h0000_0003);
      rdc(4'h1, A_UF, 32'h0000_0000);
      $display("test underflow done");
   endtask
   task automatic t_col_phys();
      ev(0, 1, 0, 0, 5'h01, 2);
      ev(0, 1, 0, 0, 5'h03, 1);
      ev(0, 1, 0, 0, 5'h00, 1);
      ev(0, 1, 0, 0, 5'h1f, 1);
      ev(0, 0, 0, 1, 5'h00, 2);
      rdc(4'h1, A_SC, 32'h0000_0002);
      rdc(4'h1, A_MC, 32'h0000_0002);
      rdc(4'h1, A_XC, 32'h0000_0002);
      $display("test physical collisions done");
   endtask
   task automatic t_col_plca();
      plca_en = 1'b1;
      ev(0, 0, 1, 0, 5'h00, 1);
      ev(0, 0, 0, 0, 5'h00, 2);
      ev(0, 1, 0, 0, 5'h00, 1);
      ev(0, 1, 0, 0, 5'h01, 1);
      ev(0, 1, 0, 0, 5'h02, 1);
      ev(0, 0, 0, 1, 5'h00, 1);
      ev(0, 1, 1, 0, 5'h00, 1);
      rdc(4'h1, A_SC, 32'h0000_0002);
      rdc(4'h1, A_MC, 32'h0000_0001);
      rdc(4'h1, A_XC, 32'h0000_0001);
      plca_en = 1'b0;
      $display("test logical collisions done");
   endtask
   task automatic t_sat();
      ev(1, 0, 0, 1, 5'h00, 1025);
      rdc(4'h1, A_UF, mts_pkg::MTS_SHORT_MAX);
      rdc(4'h1, A_XC, mts_pkg::MTS_SHORT_MAX);
      $display("test saturation done");
   endtask
   // Event landing in the same cycle as the clearing read
   task automatic t_race();
      ev(1, 0, 0, 0, 5'h00, 2);
      // Pulse covers exactly the request edge of the read
      fork
         rdc(4'h1, A_UF, 32'h0000_0002);
         begin
            underflow_abort = 1'b1;
            @(negedge ref_clk);
            underflow_abort = 1'b0;
         end
      join
      rdc(4'h1, A_UF, 32'h0000_0001);
      $display("test read race done");
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Main sequence, all drive on falling edges
   initial begin
      rst_n = 1'b0;
      cut_through_en = 1'b1;
      plca_en = 1'b0;
      underflow_abort = 1'b0;
      tx_ok = 1'b0;
      plca_logical_col = 1'b0;
      excess_col_abort = 1'b0;
      tx_col_count = 5'h00;
      // Five rising edges in reset, release on a falling edge
      repeat (5) @(posedge ref_clk);
      @(negedge ref_clk);
      rst_n = 1'b1;
      t_reset();
      t_underflow();
      t_col_phys();
      t_col_plca();
      t_sat();
      t_race();
      close_out();
   end
   // Watchdog, far beyond the roughly 1100 cycles the tests need
   initial begin
      #100000;
      fail_count++;
      close_out();
   end
endmodule // mts_tx_stats_tb
